// ===== tia_top.sv
/*
 * Timer interrupt aggregation: counter halves, expiry flags, merged
 * interrupt and per-timer clock stop bits, reached over APB.
 * Assumes timer expiry pulses and the APB master run on ref_clk_in.
 */
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tia_defs.svh"

// Function
// - High counter half is a 16-bit read/write register, reset zero.
// - Low counter half is a 16-bit register; both form the 32-bit count.
// - Each of three timers sets and holds its own flag on expiry.
// - All expiry flags merge into one interrupt request; the code merges only flags whose enable register bit is set (reset all on).
// - Third timer flag bit 2, second bit 1, first bit 0.
// - Writing one clears a flag; writing zero leaves it alone.
// - Flag register bits 15 to 3 read zero.
// - Clock gate bits 10, 12, 13 in register at index 1C02.
// - Gate bits reset to zero; zero keeps the timer clock running.
module tia_top
  import tia_pkg::*;
#(
  parameter int NUM = `TIA_NUM_TIMERS
) (
  input  wire logic           ref_clk_in,
  input  wire logic           rst_in,
  input  wire logic           psel_in,
  input  wire logic           penable_in,
  input  wire logic           pwrite_in,
  input  wire logic [15:0]    paddr_in,
  input  wire logic [31:0]    pwdata_in,
  input  wire logic [NUM-1:0] timer_expire_in,
  output logic                pready_out,
  output logic      [31:0]    prdata_out,
  output logic                pslverr_out,
  output logic                irq_out,
  output logic      [NUM-1:0] timer_clk_stop_out,
  output logic      [31:0]    timer_count_out
);

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // ************************************************************
  // Declarations
  // ************************************************************
  tia_apb_req_t          req;
  tia_apb_state_t        state_r;
  tia_apb_state_t        state_nxt;
  logic                  pready_r;
  logic                  pready_nxt;
  logic [31:0]           prdata_r;
  logic [31:0]           prdata_nxt;
  logic                  pslverr_r;
  logic                  pslverr_nxt;
  logic [`TIA_IDX_W-1:0] idx;
  logic                  hit;
  logic                  commit;
  logic                  wr_commit;
  logic [15:0]           cnt_low_r;
  logic [15:0]           cnt_low_nxt;
  logic [15:0]           cnt_high_r;
  logic [15:0]           cnt_high_nxt;
  logic [NUM-1:0]        int_en_r;
  logic [NUM-1:0]        int_en_nxt;
  logic [NUM-1:0]        gate_r;
  logic [NUM-1:0]        gate_nxt;
  logic [NUM-1:0]        flags;
  logic [NUM-1:0]        flag_clr;
  logic                  irq_r;
  logic                  irq_nxt;

  // Pack the bus request and decode the word index
  assign req.paddr  = paddr_in;
  assign req.pwrite = pwrite_in;
  assign req.pwdata = pwdata_in;
  assign idx        = req.paddr[15:2]; // Byte lanes below a word are ignored

  // Known register indexes; anything else answers with an error
  always_comb begin
    unique case (idx)
      `TIA_IDX_CNT_LOW,
      `TIA_IDX_CNT_HIGH,
      `TIA_IDX_FLAGS,
      `TIA_IDX_INT_EN,
      `TIA_IDX_INT_CLR,
      `TIA_IDX_CLK_GATE: hit = 1'b1;
      default:           hit = 1'b0;
    endcase
  end

  // ************************************************************
  // APB slave phase
  // ************************************************************
  // A transfer completes at the edge where pready_r is high in the access
  // phase; writes commit only there, so a held request cannot act twice.
  assign commit    = psel_in & penable_in & pready_r;
  assign wr_commit = commit & req.pwrite & hit;

  // Phase and answer next values
  always_comb begin
    state_nxt   = state_r;
    pready_nxt  = 1'b0;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    unique case (state_r)
      TIA_ST_IDLE: begin
        if (psel_in && penable_in) begin
          // One wait state buys a registered read path
          state_nxt   = TIA_ST_RESP;
          pready_nxt  = 1'b1;
          pslverr_nxt = ~hit;
          prdata_nxt  = 32'h0000_0000;
          if (!req.pwrite) begin
            unique case (idx)
              `TIA_IDX_CNT_LOW:  prdata_nxt[15:0] = cnt_low_r;
              `TIA_IDX_CNT_HIGH: prdata_nxt[15:0] = cnt_high_r;
              `TIA_IDX_FLAGS:    prdata_nxt[NUM-1:0] = flags;
              `TIA_IDX_INT_EN:   prdata_nxt[NUM-1:0] = int_en_r;
              `TIA_IDX_CLK_GATE: begin
                // gate bits at their spread positions
                prdata_nxt[`TIA_GATE_T0_BIT] = gate_r[0];
                prdata_nxt[`TIA_GATE_T1_BIT] = gate_r[1];
                prdata_nxt[`TIA_GATE_T2_BIT] = gate_r[2];
              end
              default:           prdata_nxt = 32'h0000_0000;
            endcase
          end
        end
      end
      TIA_ST_RESP: begin
        // Answer held for exactly one edge, then back to idle
        state_nxt = TIA_ST_IDLE;
      end
      default: begin
        state_nxt = TIA_ST_IDLE;
      end
    endcase
  end

  // Register phase and answer
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_r   <= TIA_ST_IDLE;
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign pready_out  = pready_r;
  assign prdata_out  = prdata_r;
  assign pslverr_out = pslverr_r;

  // ************************************************************
  // Counter halves
  // ************************************************************
  // high half read/write
  always_comb begin
    cnt_low_nxt  = cnt_low_r;
    cnt_high_nxt = cnt_high_r;
    if (wr_commit && idx == `TIA_IDX_CNT_LOW) begin
      cnt_low_nxt = req.pwdata[15:0];
    end
    if (wr_commit && idx == `TIA_IDX_CNT_HIGH) begin
      cnt_high_nxt = req.pwdata[15:0];
    end
  end

  // Register the halves
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_low_r  <= `TIA_CNT_RST;
      cnt_high_r <= `TIA_CNT_RST;
    end else begin
      cnt_low_r  <= cnt_low_nxt;
      cnt_high_r <= cnt_high_nxt;
    end
  end

  // halves joined into the full count
  assign timer_count_out = {cnt_high_r, cnt_low_r};

  // ************************************************************
  // Expiry flags and merged interrupt
  // ************************************************************
  // write one clears, through the flag register or the clear register
  always_comb begin
    flag_clr = '0;
    if (wr_commit && (idx == `TIA_IDX_FLAGS || idx == `TIA_IDX_INT_CLR)) begin
      flag_clr = req.pwdata[NUM-1:0];
    end
  end

  // timer n lands on flag bit n
  tia_flag_bank #(
    .NUM (NUM)
  ) u_flags (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .set_in     (timer_expire_in),
    .clr_in     (flag_clr),
    .flags_out  (flags)
  );

  // Enable register and merged request
  always_comb begin
    int_en_nxt = int_en_r;
    if (wr_commit && idx == `TIA_IDX_INT_EN) begin
      int_en_nxt = req.pwdata[NUM-1:0];
    end
    // any enabled flag raises the single request
    irq_nxt = |(flags & int_en_r);
  end

  // Register enable and request; the request lags the flag by one edge
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      int_en_r <= NUM'(`TIA_INT_EN_RST);
      irq_r    <= 1'b0;
    end else begin
      int_en_r <= int_en_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign irq_out = irq_r;

  // ************************************************************
  // Clock gating
  // ************************************************************
  // pick the three gate bits from the written word
  always_comb begin
    gate_nxt = gate_r;
    if (wr_commit && idx == `TIA_IDX_CLK_GATE) begin
      gate_nxt[0] = req.pwdata[`TIA_GATE_T0_BIT];
      gate_nxt[1] = req.pwdata[`TIA_GATE_T1_BIT];
      gate_nxt[2] = req.pwdata[`TIA_GATE_T2_BIT];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gate_r <= NUM'(`TIA_GATE_RST);
    end else begin
      gate_r <= gate_nxt;
    end
  end

  // A one stops that timer's clock; other gate register bits read zero
  assign timer_clk_stop_out = gate_r;

  // ************************************************************
  // Checks
  // ************************************************************
  a_cnt_high_wr: assert property (
    (commit && pwrite_in && idx == `TIA_IDX_CNT_HIGH)
      |=> (timer_count_out[31:16] == $past(pwdata_in[15:0])))
    else $error("high half not written");

  a_cnt_low_wr: assert property (
    (commit && pwrite_in && idx == `TIA_IDX_CNT_LOW)
      |=> (timer_count_out[15:0] == $past(pwdata_in[15:0])))
    else $error("low half not written");

  a_flag_bit2: assert property (
    timer_expire_in[2] |=> flags[`TIA_FLAG_T2_BIT])
    else $error("third timer flag misplaced");

  a_flag_bit0: assert property (
    (timer_expire_in[0] && !flag_clr[0]) ##1 (!flag_clr[0] && !timer_expire_in[0])
      |=> flags[`TIA_FLAG_T0_BIT])
    else $error("first timer flag not held");

  a_irq_merge: assert property (
    (|(flags & int_en_r)) |=> irq_out)
    else $error("merged request missing");

  a_irq_quiet: assert property (
    !(|(flags & int_en_r)) |=> !irq_out)
    else $error("merged request without enabled flag");

  a_reserved_zero: assert property (
    (pready_out && !pwrite_in && idx == `TIA_IDX_FLAGS)
      |-> (prdata_out[31:NUM] == '0))
    else $error("reserved flag bits not zero");

  a_gate_write: assert property (
    (commit && pwrite_in && idx == `TIA_IDX_CLK_GATE)
      |=> (timer_clk_stop_out == {$past(pwdata_in[`TIA_GATE_T2_BIT]),
                                  $past(pwdata_in[`TIA_GATE_T1_BIT]),
                                  $past(pwdata_in[`TIA_GATE_T0_BIT])}))
    else $error("gate bits not written");

  a_gate_reset: assert property (
    $past(rst_in) |-> (timer_clk_stop_out == '0))
    else $error("gate bits not zero after reset");

  a_apb_answer: assert property (
    (psel_in && penable_in && !pready_out) |=> pready_out ##1 !pready_out)
    else $error("answer timing wrong");

endmodule // tia_top

// ===== tia_defs.svh
/*
 * Register indexes, field positions, reset values and timing figures of the
 * timer interrupt aggregation block.
 * Assumes it is included by bare name from files that need the constants.
 */
`ifndef TIA_DEFS_SVH
`define TIA_DEFS_SVH

// ************************************************************
// Register indexes (byte address is four times the index)
// ************************************************************
`define TIA_IDX_W          14
`define TIA_IDX_CNT_LOW    14'h0000
`define TIA_IDX_CNT_HIGH   14'h0001
`define TIA_IDX_FLAGS      14'h0002
`define TIA_IDX_INT_EN     14'h0003
`define TIA_IDX_INT_CLR    14'h0004
`define TIA_IDX_CLK_GATE   14'h1c02

// ************************************************************
// Field positions
// ************************************************************
`define TIA_NUM_TIMERS     3
`define TIA_FLAG_T0_BIT    0
`define TIA_FLAG_T1_BIT    1
`define TIA_FLAG_T2_BIT    2
`define TIA_GATE_T0_BIT    10
`define TIA_GATE_T1_BIT    12
`define TIA_GATE_T2_BIT    13
`define TIA_HALF_W         16

// ************************************************************
// Reset values
// ************************************************************
`define TIA_CNT_RST        16'h0000
`define TIA_FLAGS_RST      3'h0
`define TIA_INT_EN_RST     3'h7
`define TIA_GATE_RST       3'h0

// ************************************************************
// Timing: access phase wait states before pready
// ************************************************************
`define TIA_WAIT_STATES    1

`endif

// ===== tia_pkg.sv
/*
 * Types shared by the timer interrupt aggregation block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tia_pkg;

  // ************************************************************
  // Bus request as captured during the access phase
  // ************************************************************
  typedef struct packed {
    logic [15:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } tia_apb_req_t;

  // ************************************************************
  // Bus slave phase, one-hot
  // ************************************************************
  typedef enum logic [1:0] {
    TIA_ST_IDLE = 2'b01,
    TIA_ST_RESP = 2'b10
  } tia_apb_state_t;

endpackage

// ===== tia_flag_bank.sv
/*
 * Sticky expiry flags, one per timer, set by hardware, cleared by write-one.
 * Assumes set and clear pulses come from logic on ref_clk_in.
 */
`timescale 1ns/1ps
`include "tia_defs.svh"

module tia_flag_bank #(
  parameter int NUM = `TIA_NUM_TIMERS
) (
  input  wire logic           ref_clk_in,
  input  wire logic           rst_in,
  input  wire logic [NUM-1:0] set_in,
  input  wire logic [NUM-1:0] clr_in,
  output logic      [NUM-1:0] flags_out
);

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  logic [NUM-1:0] flags_r;
  logic [NUM-1:0] flags_nxt;

  // ************************************************************
  // One flag per timer
  // ************************************************************
  for (genvar i = 0; i < NUM; i++) begin : g_flag
    always_comb begin
      flags_nxt[i] = set_in[i] | (flags_r[i] & ~clr_in[i]);
    end

    a_flag_set: assert property (set_in[i] |=> flags_r[i])
      else $error("flag not set after expiry");
    a_set_wins: assert property ((set_in[i] && clr_in[i]) |=> flags_r[i])
      else $error("expiry lost under clear");
    a_w1c_clear: assert property ((clr_in[i] && !set_in[i]) |=> !flags_r[i])
      else $error("flag not cleared by write one");
    a_flag_hold: assert property ((flags_r[i] && !clr_in[i]) |=> flags_r[i])
      else $error("flag dropped without clear");
  end

  // Register the flags
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      flags_r <= NUM'(`TIA_FLAGS_RST);
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_out = flags_r;

endmodule // tia_flag_bank

// ===== test_timer_interrupt_aggregation.sv
/*
 * Self-checking bench for the timer interrupt aggregation block.
 * Assumes tia_top and tia_defs.svh are compiled alongside; single clock.
 */
`timescale 1ns/1ps
`include "tia_defs.svh"

module test_timer_interrupt_aggregation;
  import tia_pkg::*;

  // ************************************************************
  // Signals and counters
  // ************************************************************
  logic        ref_clk_in;
  logic        rst_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [15:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [2:0]  timer_expire_in;
  logic        pready_out;
  logic [31:0] prdata_out;
  logic        pslverr_out;
  logic        irq_out;
  logic [2:0]  timer_clk_stop_out;
  logic [31:0] timer_count_out;
  int          n_errors;
  int          samples_checked;
  int          cycles;
  logic [31:0] d;
  logic        e;

  typedef struct {
    logic [`TIA_IDX_W-1:0] idx;
    logic [31:0]           wd;
    logic [31:0]           rd;
    logic                  err;
  } tia_row_t;
  tia_row_t rows [8];

  tia_top u_dut (
    .ref_clk_in         (ref_clk_in),
    .rst_in             (rst_in),
    .psel_in            (psel_in),
    .penable_in         (penable_in),
    .pwrite_in          (pwrite_in),
    .paddr_in           (paddr_in),
    .pwdata_in          (pwdata_in),
    .timer_expire_in    (timer_expire_in),
    .pready_out         (pready_out),
    .prdata_out         (prdata_out),
    .pslverr_out        (pslverr_out),
    .irq_out            (irq_out),
    .timer_clk_stop_out (timer_clk_stop_out),
    .timer_count_out    (timer_count_out)
  );

  // Clock of 5 ns period
  always #2.5 ref_clk_in = ~ref_clk_in;

  // ************************************************************
  // Helper tasks
  // ************************************************************
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; reads at the edge are pre-update, so pready is the sampled value
  task automatic apb(input logic wr, input logic [`TIA_IDX_W-1:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge ref_clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= {idx, 2'b00};
    pwdata_in  <= wd;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    // Wait for the answer as long as it takes; only the hang guard ends this
    do begin
      @(posedge ref_clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [`TIA_IDX_W-1:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, d, e);
  endtask

  task automatic rdc(input logic [`TIA_IDX_W-1:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000, d, e);
    chk(d, exp);
  endtask

  // Single-cycle expiry pulse, then wait for the flag and interrupt to land
  task automatic expire(input logic [2:0] m);
    @(posedge ref_clk_in);
    timer_expire_in <= m;
    @(posedge ref_clk_in);
    timer_expire_in <= 3'h0;
    repeat (2) @(posedge ref_clk_in);
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    ref_clk_in = 1'b0;
    rst_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 16'h0000;
    pwdata_in = 32'h0000_0000;
    timer_expire_in = 3'h0;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    rows = '{
      '{`TIA_IDX_CNT_HIGH, 32'hdead_beef, 32'h0000_beef, 1'b0},
      '{`TIA_IDX_CNT_LOW,  32'h1234_5678, 32'h0000_5678, 1'b0},
      '{`TIA_IDX_CLK_GATE, 32'hffff_ffff, 32'h0000_3400, 1'b0},
      '{`TIA_IDX_FLAGS,    32'hffff_ffff, 32'h0000_0000, 1'b0},
      '{`TIA_IDX_INT_CLR,  32'h0000_0007, 32'h0000_0000, 1'b0},
      '{14'h0005,          32'hffff_ffff, 32'h0000_0000, 1'b1},
      '{`TIA_IDX_INT_EN,   32'hffff_fff7, 32'h0000_0007, 1'b0},
      '{`TIA_IDX_CLK_GATE, 32'h0000_1000, 32'h0000_1000, 1'b0}
    };
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;

    // Reset values of registers and outputs
    rdc(`TIA_IDX_CNT_HIGH, 32'h0000_0000);
    rdc(`TIA_IDX_CLK_GATE, 32'h0000_0000);
    rdc(`TIA_IDX_FLAGS, 32'h0000_0000);
    chk({29'h0, timer_clk_stop_out}, 32'h0000_0000);
    chk({31'h0, irq_out}, 32'h0000_0000);
    $display("test reset done");

    // Register rows: write, then read back masked value and error
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd, d, e);
      chk({31'h0, e}, {31'h0, rows[i].err});
      apb(1'b0, rows[i].idx, 32'h0000_0000, d, e);
      chk(d, rows[i].rd);
      chk({31'h0, e}, {31'h0, rows[i].err});
    end
    chk(timer_count_out, 32'hbeef_5678);
    chk({29'h0, timer_clk_stop_out}, 32'h0000_0002);
    $display("test rows done");

    // Each timer sets its own bit, raises the merged line, clears by write-one
    for (int n = 0; n < 3; n++) begin
      expire(3'h1 << n);
      chk({31'h0, irq_out}, 32'h0000_0001);
      rdc(`TIA_IDX_FLAGS, 32'h1 << n);
      wr(`TIA_IDX_FLAGS, ~(32'h1 << n));
      rdc(`TIA_IDX_FLAGS, 32'h1 << n);
      wr(`TIA_IDX_FLAGS, 32'h1 << n);
      repeat (2) @(posedge ref_clk_in);
      chk({31'h0, irq_out}, 32'h0000_0000);
      rdc(`TIA_IDX_FLAGS, 32'h0000_0000);
    end
    $display("test flags done");

    // Two timers at once, clear one of them only
    expire(3'h5);
    rdc(`TIA_IDX_FLAGS, 32'h0000_0005);
    wr(`TIA_IDX_FLAGS, 32'h0000_0004);
    rdc(`TIA_IDX_FLAGS, 32'h0000_0001);
    wr(`TIA_IDX_FLAGS, 32'h0000_0001);
    $display("test pair done");

    // Masked flag keeps the line low until enabled, clear register clears the flag
    wr(`TIA_IDX_INT_EN, 32'h0000_0000);
    expire(3'h2);
    chk({31'h0, irq_out}, 32'h0000_0000);
    wr(`TIA_IDX_INT_EN, 32'h0000_0002);
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, irq_out}, 32'h0000_0001);
    wr(`TIA_IDX_INT_CLR, 32'h0000_0002);
    rdc(`TIA_IDX_FLAGS, 32'h0000_0000);
    wr(`TIA_IDX_INT_EN, 32'h0000_0007);
    $display("test mask done");

    // Expiry held through the clearing write: the new event must survive
    expire(3'h1);
    @(posedge ref_clk_in);
    timer_expire_in <= 3'h1;
    wr(`TIA_IDX_FLAGS, 32'h0000_0001);
    timer_expire_in <= 3'h0;
    rdc(`TIA_IDX_FLAGS, 32'h0000_0001);
    $display("test set wins done");

    // Second reset mid-run brings everything back
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rdc(`TIA_IDX_FLAGS, 32'h0000_0000);
    rdc(`TIA_IDX_CNT_HIGH, 32'h0000_0000);
    chk({29'h0, timer_clk_stop_out}, 32'h0000_0000);
    chk({31'h0, irq_out}, 32'h0000_0000);
    $display("test rereset done");
    tally_and_finish();
  end

endmodule // test_timer_interrupt_aggregation
